//--- hdl/can_filter_pkg.sv
`default_nettype none
package can_filter_pkg;
  // geometry
  localparam int NUM_OBJ    = 6;   // message objects
  localparam int OBJ_W      = 3;   // object select width
  localparam int IDX_W      = 3;   // data index width, eight positions
  localparam int DEPTH      = 8;   // data bytes per object
  localparam int ADDR_W     = 8;   // register byte address width
  localparam int STAMP_W    = 16;  // frame time count width

  // register byte offsets, one aligned word each
  localparam logic [7:0] PAGE_OFS  = 8'h00;
  localparam logic [7:0] MASK4_OFS = 8'h04;
  localparam logic [7:0] MASK3_OFS = 8'h08;
  localparam logic [7:0] MASK2_OFS = 8'h0C;
  localparam logic [7:0] MASK1_OFS = 8'h10;
  localparam logic [7:0] STML_OFS  = 8'h14;
  localparam logic [7:0] STMH_OFS  = 8'h18;
  localparam logic [7:0] DATA_OFS  = 8'h1C;
  localparam logic [7:0] TAG_OFS   = 8'h20;
  localparam logic [7:0] CTRL_OFS  = 8'h24;

  // page register fields
  localparam int PAGE_IDX_LSB  = 0;
  localparam int PAGE_AOFF_BIT = 3;
  localparam int PAGE_OBJ_LSB  = 4;
  // object control fields
  localparam int CTRL_RXEN_BIT = 0;
  localparam int CTRL_EXT_BIT  = 1;
  localparam int CTRL_HIT_BIT  = 2;
  // mask group fields
  localparam int STD_ID_LSB = 21;
  localparam int EXT_ID_LSB = 3;
  localparam int RTR_BIT    = 2;
  localparam int EXT_TAG_BIT = 0;
  localparam logic [31:0] CARE_STD = 32'hFFE0_0005;
  localparam logic [31:0] CARE_EXT = 32'hFFFF_FFFD;

  // reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [15:0] STAMP_RST = 16'h0000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // word select compare, low two address bits ignored
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  // received frame laid out like the mask group
  function automatic logic [31:0] frame_word(input logic ext, input logic [28:0] id,
                                             input logic rtr);
    if (ext) begin
      return {id, rtr, 1'b0, ext};
    end
    return {id[10:0], 18'h00000, rtr, 1'b0, ext};
  endfunction
endpackage
`default_nettype wire

//--- hdl/filt_if.sv
`timescale 1ns/1ns
`default_nettype none
// one object's acceptance compare
interface filt_if;
  logic [31:0] mask;      // compare enables
  logic [31:0] tag;       // expected frame word
  logic        ext_mode;  // object frame format
  logic        enabled;   // object armed for reception
  logic [31:0] frame;     // incoming frame word
  logic        hit;       // object accepts frame
  modport filt (input mask, tag, ext_mode, enabled, frame, output hit);
  modport ctl  (output mask, tag, ext_mode, enabled, frame, input hit);
endinterface
`default_nettype wire

//--- hdl/acceptance_filter.sv
`timescale 1ns/1ns
`default_nettype none
module acceptance_filter (
  filt_if.filt f
);
  import can_filter_pkg::*;

  logic [31:0] care;  // bits that really compare

  // cleared mask bit forces a pass, set bit compares only where the frame format's care bits allow
  always_comb begin
    care  = f.mask & (f.ext_mode ? CARE_EXT : CARE_STD);
    f.hit = f.enabled && (((f.frame ^ f.tag) & care) == 32'h0000_0000);
  end
endmodule
`default_nettype wire

//--- hdl/can_mask_stamp_data_access.sv
`timescale 1ns/1ns
`default_nettype none
module can_mask_stamp_data_access (
  input  wire logic                               mclk,
  input  wire logic                               reset,
  input  wire logic [can_filter_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                               awvalid,
  output logic                                    awready,
  input  wire logic [31:0]                        wdata,
  input  wire logic [3:0]                         wstrb,
  input  wire logic                               wvalid,
  output logic                                    wready,
  output logic [1:0]                              bresp,
  output logic                                    bvalid,
  input  wire logic                               bready,
  input  wire logic [can_filter_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                               arvalid,
  output logic                                    arready,
  output logic [31:0]                             rdata,
  output logic [1:0]                              rresp,
  output logic                                    rvalid,
  input  wire logic                               rready,
  input  wire logic                               bit_tick,
  input  wire logic                               rx_frame_valid,
  input  wire logic [28:0]                        rx_ident,
  input  wire logic                               rx_remote,
  input  wire logic                               rx_extended,
  output logic [can_filter_pkg::NUM_OBJ-1:0]      accept_hit
);
  import can_filter_pkg::*;

  // bus channel state
  logic              aw_held_r;   // write address captured
  logic              w_held_r;    // write data captured
  logic [ADDR_W-1:0] aw_addr_r;   // captured write address
  logic [31:0]       w_data_r;    // captured write data
  logic [3:0]        w_strb_r;    // captured byte enables
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  // page and object state
  logic [OBJ_W-1:0]  obj_sel_r;   // selected message object
  logic [IDX_W-1:0]  data_idx_r;  // byte index in the object
  logic              auto_off_r;  // auto increment disabled
  logic [31:0]       mask_r    [NUM_OBJ];
  logic [31:0]       tag_r     [NUM_OBJ];
  logic [15:0]       stamp_r   [NUM_OBJ];
  logic [7:0]        data_r    [NUM_OBJ*DEPTH];
  logic [NUM_OBJ-1:0] rx_en_r;    // object armed for reception
  logic [NUM_OBJ-1:0] ext_r;      // extension flag per object
  logic [NUM_OBJ-1:0] hit_flag_r; // sticky frame accepted
  logic [STAMP_W-1:0] frame_time_count_r;
  logic [NUM_OBJ-1:0] accept_hit_r;

  // decode helpers
  logic              aw_take;
  logic              w_take;
  logic              wr_go;       // write performed this cycle
  logic              rd_go;       // read taken this cycle
  logic              obj_ok;      // selection names a real object
  logic [OBJ_W-1:0]  obj_use;     // selection clamped for reads
  logic [5:0]        data_at;     // flat data byte address
  logic              dw_wr;
  logic              dw_rd;
  logic              page_wr;
  logic [1:0]        idx_step;
  logic [31:0]       rd_data_c;
  logic              rd_err_c;
  logic              wr_err_c;
  logic [31:0]       rx_word;
  logic [NUM_OBJ-1:0] hit_c;

  assign aw_take = awvalid & awready_r;
  assign w_take  = wvalid & wready_r;
  // response slot must be free before the next write acts
  assign wr_go   = aw_held_r & w_held_r & ~bvalid_r;
  assign rd_go   = arvalid & arready_r;
  assign obj_ok  = obj_sel_r < OBJ_W'(NUM_OBJ);
  assign obj_use = obj_ok ? obj_sel_r : '0;
  assign data_at = {obj_use, data_idx_r};
  assign rx_word = frame_word(rx_extended, rx_ident, rx_remote);

  // data window accesses; an empty selection does nothing
  assign dw_wr   = wr_go & addr_is(aw_addr_r, DATA_OFS) & obj_ok;
  assign dw_rd   = rd_go & addr_is(araddr, DATA_OFS) & obj_ok;
  assign page_wr = wr_go & addr_is(aw_addr_r, PAGE_OFS) & w_strb_r[0];
  assign idx_step = {1'b0, dw_wr} + {1'b0, dw_rd};

  // write address channel
  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      awready_r <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      awready_r <= ~((aw_held_r | aw_take) & ~wr_go);
    end
  end

  // write data channel, taken independently of the address
  always_ff @(posedge mclk) begin
    if (reset) begin
      w_held_r <= 1'b0;
      w_data_r <= WORD_RST;
      w_strb_r <= 4'h0;
      wready_r <= 1'b0;
    end else begin
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
      wready_r <= ~((w_held_r | w_take) & ~wr_go);
    end
  end

  // unmapped and stamp writes, and object register writes with an empty selection, answer with an error
  always_comb begin
    wr_err_c = 1'b0;
    if (addr_is(aw_addr_r, PAGE_OFS)) begin
      wr_err_c = 1'b0;
    end else if (addr_is(aw_addr_r, STML_OFS) || addr_is(aw_addr_r, STMH_OFS)) begin
      wr_err_c = 1'b1;
    end else if (addr_is(aw_addr_r, MASK4_OFS) || addr_is(aw_addr_r, MASK3_OFS) ||
                 addr_is(aw_addr_r, MASK2_OFS) || addr_is(aw_addr_r, MASK1_OFS) ||
                 addr_is(aw_addr_r, DATA_OFS) || addr_is(aw_addr_r, TAG_OFS) ||
                 addr_is(aw_addr_r, CTRL_OFS)) begin
      wr_err_c = ~obj_ok;
    end else begin
      wr_err_c = 1'b1;
    end
  end

  // write response
  always_ff @(posedge mclk) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_err_c ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // page select and data index
  always_ff @(posedge mclk) begin
    if (reset) begin
      obj_sel_r  <= '0;
      data_idx_r <= '0;
      auto_off_r <= 1'b0;
    end else if (page_wr) begin
      // a fresh page write restarts the index where software asks
      obj_sel_r  <= w_data_r[PAGE_OBJ_LSB +: OBJ_W];
      data_idx_r <= w_data_r[PAGE_IDX_LSB +: IDX_W];
      auto_off_r <= w_data_r[PAGE_AOFF_BIT];
    end else if (!auto_off_r) begin
      // both windows in one cycle advance by two; wrap is free
      data_idx_r <= data_idx_r + IDX_W'(idx_step);
    end
  end

  // identifier mask bytes, stored as written
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int o = 0; o < NUM_OBJ; o++) begin
        mask_r[o] <= WORD_RST;
      end
    end else if (wr_go && obj_ok && w_strb_r[0]) begin
      // reserved bits are kept so a read returns what was written
      if (addr_is(aw_addr_r, MASK4_OFS)) begin
        mask_r[obj_sel_r][7:0] <= w_data_r[7:0];
      end
      if (addr_is(aw_addr_r, MASK3_OFS)) begin
        mask_r[obj_sel_r][15:8] <= w_data_r[7:0];
      end
      if (addr_is(aw_addr_r, MASK2_OFS)) begin
        mask_r[obj_sel_r][23:16] <= w_data_r[7:0];
      end
      if (addr_is(aw_addr_r, MASK1_OFS)) begin
        mask_r[obj_sel_r][31:24] <= w_data_r[7:0];
      end
    end
  end

  // identifier tag word, byte lanes honoured
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int o = 0; o < NUM_OBJ; o++) begin
        tag_r[o] <= WORD_RST;
      end
    end else if (wr_go && obj_ok && addr_is(aw_addr_r, TAG_OFS)) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_r[b]) begin
          tag_r[obj_sel_r][8*b +: 8] <= w_data_r[8*b +: 8];
        end
      end
    end
  end

  // object data bytes behind the window
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < NUM_OBJ*DEPTH; i++) begin
        data_r[i] <= BYTE_RST;
      end
    end else if (dw_wr && w_strb_r[0]) begin
      data_r[data_at] <= w_data_r[7:0];
    end
  end

  // free running frame time counter
  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_time_count_r <= STAMP_RST;
    end else if (bit_tick) begin
      frame_time_count_r <= frame_time_count_r + 16'h0001;
    end
  end

  // one compare unit per object
  for (genvar o = 0; o < NUM_OBJ; o++) begin : g_obj
    filt_if f ();
    assign f.mask     = mask_r[o];
    assign f.tag      = {tag_r[o][31:1], ext_r[o]};
    assign f.ext_mode = ext_r[o];
    assign f.enabled  = rx_en_r[o];
    assign f.frame    = rx_word;
    assign hit_c[o]   = f.hit;
    acceptance_filter u_filt (
      .f (f)
    );
  end

  // object control, sticky hit; a new hit beats a clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_en_r    <= '0;
      ext_r      <= '0;
      hit_flag_r <= '0;
    end else begin
      for (int o = 0; o < NUM_OBJ; o++) begin
        if (wr_go && w_strb_r[0] && addr_is(aw_addr_r, CTRL_OFS) &&
            obj_sel_r == OBJ_W'(o)) begin
          rx_en_r[o] <= w_data_r[CTRL_RXEN_BIT];
          ext_r[o]   <= w_data_r[CTRL_EXT_BIT];
          hit_flag_r[o] <= (hit_flag_r[o] & ~w_data_r[CTRL_HIT_BIT]) |
                           (rx_frame_valid & hit_c[o]);
        end else if (rx_frame_valid && hit_c[o]) begin
          hit_flag_r[o] <= 1'b1;
        end
      end
    end
  end

  // stamp taken when an object accepts a frame
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int o = 0; o < NUM_OBJ; o++) begin
        stamp_r[o] <= STAMP_RST;
      end
      accept_hit_r <= '0;
    end else begin
      for (int o = 0; o < NUM_OBJ; o++) begin
        if (rx_frame_valid && hit_c[o]) begin
          stamp_r[o] <= frame_time_count_r;
        end
      end
      accept_hit_r <= rx_frame_valid ? hit_c : '0;
    end
  end

  // read decode; high stamp byte is not latched with the low one
  always_comb begin
    rd_data_c = WORD_RST;
    rd_err_c  = ~obj_ok;
    case (araddr[ADDR_W-1:2])
      PAGE_OFS[7:2]: begin
        rd_err_c  = 1'b0;
        rd_data_c = {24'h000000, 1'b0, obj_sel_r, auto_off_r, data_idx_r};
      end
      MASK4_OFS[7:2]: rd_data_c = {24'h000000, mask_r[obj_use][7:0]};
      MASK3_OFS[7:2]: rd_data_c = {24'h000000, mask_r[obj_use][15:8]};
      MASK2_OFS[7:2]: rd_data_c = {24'h000000, mask_r[obj_use][23:16]};
      MASK1_OFS[7:2]: rd_data_c = {24'h000000, mask_r[obj_use][31:24]};
      STML_OFS[7:2]:  rd_data_c = {24'h000000, stamp_r[obj_use][7:0]};
      STMH_OFS[7:2]:  rd_data_c = {24'h000000, stamp_r[obj_use][15:8]};
      DATA_OFS[7:2]:  rd_data_c = {24'h000000, data_r[data_at]};
      TAG_OFS[7:2]:   rd_data_c = tag_r[obj_use];
      CTRL_OFS[7:2]: begin
        rd_data_c = {29'h00000000, hit_flag_r[obj_use], ext_r[obj_use], rx_en_r[obj_use]};
      end
      default: begin
        rd_err_c  = 1'b1;
        rd_data_c = WORD_RST;
      end
    endcase
    if (rd_err_c) begin
      rd_data_c = WORD_RST;
    end
  end

  // read channel, one read outstanding
  always_ff @(posedge mclk) begin
    if (reset) begin
      rvalid_r  <= 1'b0;
      rdata_r   <= WORD_RST;
      rresp_r   <= RESP_OKAY;
      arready_r <= 1'b0;
    end else begin
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_data_c;
        rresp_r  <= rd_err_c ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
      arready_r <= ~(rd_go | (rvalid_r & ~rready));
    end
  end

  assign awready    = awready_r;
  assign wready     = wready_r;
  assign bvalid     = bvalid_r;
  assign bresp      = bresp_r;
  assign arready    = arready_r;
  assign rvalid     = rvalid_r;
  assign rdata      = rdata_r;
  assign rresp      = rresp_r;
  assign accept_hit = accept_hit_r;

  // both write halves captured, then one response
  sequence both_held;
    aw_held_r && w_held_r && !bvalid_r;
  endsequence
  sequence resp_up;
    ##1 bvalid_r;
  endsequence

  a_write_resp: assert property (@(posedge mclk) disable iff (reset)
    both_held |-> resp_up)
    else $error("write response missing");

  a_index_wrap: assert property (@(posedge mclk) disable iff (reset)
    dw_rd && !dw_wr && !page_wr && !auto_off_r && data_idx_r == 3'h7
    |=> data_idx_r == 3'h0)
    else $error("data index did not wrap");

  a_index_step: assert property (@(posedge mclk) disable iff (reset)
    (dw_rd || dw_wr) && !page_wr && !auto_off_r
    |=> data_idx_r != $past(data_idx_r))
    else $error("data index did not advance");

  a_index_still: assert property (@(posedge mclk) disable iff (reset)
    auto_off_r && !page_wr |=> $stable(data_idx_r))
    else $error("data index moved with auto off");

  a_stamp_wrap: assert property (@(posedge mclk) disable iff (reset)
    bit_tick && frame_time_count_r == 16'hFFFF |=> frame_time_count_r == 16'h0000)
    else $error("stamp counter did not wrap");

  a_stamp_read: assert property (@(posedge mclk) disable iff (reset)
    rd_go && addr_is(araddr, STMH_OFS) && obj_ok
    |=> rvalid_r && rdata_r == {24'h000000, $past(stamp_r[obj_sel_r][15:8])})
    else $error("stamp high byte read wrong");

  a_mask_pass: assert property (@(posedge mclk) disable iff (reset)
    rx_frame_valid && rx_en_r[0] && mask_r[0] == 32'h0000_0000 |=> accept_hit_r[0])
    else $error("cleared mask did not force pass");

  a_id_mismatch: assert property (@(posedge mclk) disable iff (reset)
    rx_frame_valid && !ext_r[0] &&
    ((rx_word[31:21] ^ tag_r[0][31:21]) & mask_r[0][31:21]) != 11'h000
    |=> !accept_hit_r[0])
    else $error("mismatched identifier accepted");

  a_mask_store: assert property (@(posedge mclk) disable iff (reset)
    wr_go && obj_ok && w_strb_r[0] && addr_is(aw_addr_r, MASK1_OFS)
    |=> mask_r[$past(obj_sel_r)][31:24] == $past(w_data_r[7:0]))
    else $error("mask byte one not stored");
endmodule
`default_nettype wire

//--- dv/can_node_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side of the block: other nodes on the bus, seen through the bit
// clock tick and the decoded fields of each received frame
module can_node_model (
  input  wire logic        mclk,
  output logic             bit_tick,
  output logic             rx_frame_valid,
  output logic [28:0]      rx_ident,
  output logic             rx_remote,
  output logic             rx_extended
);
  // quiet bus at time zero
  initial begin
    bit_tick = 1'b0;
    rx_frame_valid = 1'b0;
    rx_ident = 29'h0AAA_AAAA;
    rx_remote = 1'b1;
    rx_extended = 1'b1;
  end

  // n bit times back to back, one pulse per cycle
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      bit_tick <= 1'b1;
    end
    @(posedge mclk);
    bit_tick <= 1'b0;
  endtask

  // one received frame, fields valid for exactly one cycle
  task automatic send(input logic e, input logic [28:0] id, input logic r);
    @(posedge mclk);
    rx_frame_valid <= 1'b1;
    rx_ident <= id;        // standard frames carry bits 10:0 only
    rx_remote <= r;
    rx_extended <= e;
    @(posedge mclk);
    rx_frame_valid <= 1'b0;
    // stale fields are not kept: invert them so nothing leans on them
    rx_ident <= ~id;
    rx_remote <= ~r;
    rx_extended <= ~e;
  endtask
endmodule
`default_nettype wire

//--- dv/can_mask_stamp_data_access_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module can_mask_stamp_data_access_tb_top;
  import can_filter_pkg::*;
  logic        mclk;       // 250 MHz
  logic        reset;      // synchronous, active high
  logic [7:0]  awaddr;     // write address channel
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;      // write data channel
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;      // write response
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;     // read address channel
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;      // read data channel
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        bit_tick;   // from the node model
  logic        rx_frame_valid;
  logic [28:0] rx_ident;
  logic        rx_remote;
  logic        rx_extended;
  logic [5:0]  accept_hit;
  int          num_errors; // mismatches
  int          n_checks;   // comparisons made

  can_mask_stamp_data_access dut_u (.mclk(mclk), .reset(reset), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .bit_tick(bit_tick), .rx_frame_valid(rx_frame_valid),
    .rx_ident(rx_ident), .rx_remote(rx_remote), .rx_extended(rx_extended),
    .accept_hit(accept_hit));

  can_node_model node_u (.mclk(mclk), .bit_tick(bit_tick), .rx_frame_valid(rx_frame_valid),
    .rx_ident(rx_ident), .rx_remote(rx_remote), .rx_extended(rx_extended));

  // free running clock
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run, also reached by the watchdog
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // bus write: both halves offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // no fixed latency assumed, the watchdog bounds the wait
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  // bus read with data and response compare
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask

  // select object, load mask bytes with readback, tag and control
  task automatic obj_cfg(input logic [2:0] o, input logic [31:0] m, input logic [31:0] t,
                         input logic [1:0] c);
    wr(PAGE_OFS, {25'h0, o, 4'h0}, RESP_OKAY);
    for (int b = 0; b < 4; b++) begin
      wr(MASK4_OFS + 8'(4 * b), {24'h0, m[8*b +: 8]}, RESP_OKAY);
      rd(MASK4_OFS + 8'(4 * b), {24'h0, m[8*b +: 8]}, RESP_OKAY);
    end
    wr(TAG_OFS, t, RESP_OKAY);
    wr(CTRL_OFS, {30'h0, c}, RESP_OKAY);
  endtask

  // one frame from the bus and the acceptance pulse a cycle later
  task automatic frm(input logic e, input logic [28:0] id, input logic r, input logic [5:0] h);
    node_u.send(e, id, r);
    #1;
    chk(32'(accept_hit), 32'(h));
  endtask

  // stuck bus or filter: full run is about 66k cycles
  initial begin
    #400000;
    num_errors++;
    summarize();
  end

  // main sequence
  initial begin
    num_errors = 0;
    n_checks = 0;
    reset = 1'b1;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    wstrb <= 4'hF;
    rd(PAGE_OFS, 32'h0, RESP_OKAY);
    rd(CTRL_OFS, 32'h0, RESP_OKAY);
    rd(8'h30, 32'h0, RESP_SLVERR);
    $display("test reset done");
    obj_cfg(3'd0, 32'hFFE0_0005, {11'h5A3, 21'h0}, 2'b01);
    obj_cfg(3'd1, 32'hFFFF_FFFD, {29'h0ABC_DEF5, 3'h0}, 2'b11);
    $display("test mask done");
    // one tick per bit time of the externally programmed bit timing
    node_u.tick(291);
    frm(1'b0, 29'h5A3, 1'b0, 6'b000001);
    frm(1'b0, 29'h5A2, 1'b0, 6'b000000);
    frm(1'b0, 29'h5A3, 1'b1, 6'b000000);
    frm(1'b1, 29'h0ABC_DEF5, 1'b0, 6'b000010);
    frm(1'b1, 29'h0ABC_DEF4, 1'b0, 6'b000000);
    $display("test filter done");
    wr(PAGE_OFS, 32'h0, RESP_OKAY);
    rd(STML_OFS, 32'h23, RESP_OKAY);
    rd(STMH_OFS, 32'h01, RESP_OKAY);
    wr(STML_OFS, 32'hFF, RESP_SLVERR);
    rd(STML_OFS, 32'h23, RESP_OKAY);
    rd(CTRL_OFS, 32'h5, RESP_OKAY);
    $display("test stamp done");
    // wrap the frame time count: 291 + 65247 ticks leaves 2
    node_u.tick(65247);
    obj_cfg(3'd0, 32'hFFC0_0000, {11'h5A3, 21'h0}, 2'b01);
    frm(1'b0, 29'h5A2, 1'b1, 6'b000001);
    frm(1'b1, 29'h168C_0000, 1'b0, 6'b000001);
    wr(PAGE_OFS, 32'h0, RESP_OKAY);
    rd(STML_OFS, 32'h02, RESP_OKAY);
    rd(STMH_OFS, 32'h00, RESP_OKAY);
    $display("test wrap done");
    // ten writes from index 6 run past the end and overwrite 6 and 7
    wr(PAGE_OFS, 32'h26, RESP_OKAY);
    for (int i = 0; i < 10; i++) begin
      wr(DATA_OFS, 32'hA0 + 32'(i), RESP_OKAY);
    end
    wr(PAGE_OFS, 32'h20, RESP_OKAY);
    for (int k = 0; k < 9; k++) begin
      rd(DATA_OFS, 32'hA2 + 32'(k % 8), RESP_OKAY);
    end
    // increment off: the index stays put
    wr(PAGE_OFS, 32'h2B, RESP_OKAY);
    rd(DATA_OFS, 32'hA5, RESP_OKAY);
    rd(DATA_OFS, 32'hA5, RESP_OKAY);
    $display("test window done");
    // all-clear mask on object 0 accepts any frame, then its hit flag is cleared
    obj_cfg(3'd0, 32'h0, 32'hFFFF_FFFF, 2'b11);
    frm(1'b1, 29'h1555_5555, 1'b1, 6'b000001);
    rd(CTRL_OFS, 32'h7, RESP_OKAY);
    wr(CTRL_OFS, 32'h7, RESP_OKAY);
    rd(CTRL_OFS, 32'h3, RESP_OKAY);
    $display("test clear done");
    // object select past the last object
    wr(PAGE_OFS, 32'h60, RESP_OKAY);
    rd(DATA_OFS, 32'h0, RESP_SLVERR);
    wr(DATA_OFS, 32'h55, RESP_SLVERR);
    $display("test select done");
    summarize();
  end
endmodule
`default_nettype wire
